// file: shared/fe_pkg.sv
// Shared constants and types of the fine-edge pulse-width channel
package fe_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FINE_STEP_PS  = 250;
  localparam int FINE_STEPS    = CLK_PERIOD_PS / FINE_STEP_PS;
  localparam int FW            = $clog2(FINE_STEPS);
  localparam int CW            = 14;
  localparam int EW            = CW + FW;
  localparam int AW            = 12;
  localparam int ADW           = 8;
  localparam int NUM_SIDES     = 2;

  localparam logic [ADW-1:0] REG_CTRL    = 8'h00;
  localparam logic [ADW-1:0] REG_PERIOD  = 8'h04;
  localparam logic [ADW-1:0] REG_EVENT1  = 8'h08;
  localparam logic [ADW-1:0] REG_EVENT2  = 8'h0c;
  localparam logic [ADW-1:0] REG_EVENT3  = 8'h10;
  localparam logic [ADW-1:0] REG_EVENT4  = 8'h14;
  localparam logic [ADW-1:0] REG_SAMPLE  = 8'h18;
  localparam logic [ADW-1:0] REG_PHASE   = 8'h1c;
  localparam logic [ADW-1:0] REG_CYCADJ  = 8'h20;
  localparam logic [ADW-1:0] REG_WINDOW  = 8'h24;
  localparam logic [ADW-1:0] REG_THRESH  = 8'h28;
  localparam logic [ADW-1:0] REG_MONITOR = 8'h2c;
  localparam logic [ADW-1:0] REG_STATUS  = 8'h30;

  localparam int CTRL_EN     = 0;
  localparam int CTRL_FINE   = 1;
  localparam int CTRL_SCALE  = 2;
  localparam int CTRL_OS     = 5;
  localparam int CTRL_FOLLOW = 7;
  localparam int CTRL_SRC    = 8;
  localparam int CTRL_IDIV   = 10;
  localparam int CTRL_AUTO   = 14;
  localparam int HI_LSB      = 16;
  localparam int WIN_LEN     = 8;
  localparam int THR_HI      = 8;
  localparam int THR_STEP    = 16;

  localparam logic [31:0] CTRL_MASK   = 32'h0000_7fff;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [CW-1:0] PERIOD_RST = 14'h00f9;
  localparam logic [EW-1:0] EVENT_RST = 18'h00000;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  localparam logic [2:0] SCALE_MAX    = 3'h4;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  localparam logic [7:0] IDIV_COUNT [16] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'h07, 8'h0f,
    8'h1f, 8'h2f, 8'h3f, 8'h4f, 8'h5f, 8'h7f, 8'h9f, 8'hbf, 8'hdf, 8'hff};

  typedef enum logic [1:0] {
    FE_WIN_IDLE  = 2'b00,
    FE_WIN_BLANK = 2'b01,
    FE_WIN_OPEN  = 2'b10
  } fe_win_e;

  typedef struct packed {
    logic           awvalid;
    logic [ADW-1:0] awaddr;
    logic           wvalid;
    logic [31:0]    wdata;
    logic [3:0]     wstrb;
    logic           bready;
    logic           arvalid;
    logic [ADW-1:0] araddr;
    logic           rready;
  } fe_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fe_axi_resp_s;

  typedef struct packed {
    logic [31:0]                 ctrl;
    logic [CW-1:0]               period;
    logic [CW-1:0]               event1;
    logic [EW-1:0]               event2;
    logic [EW-1:0]               event3;
    logic [EW-1:0]               event4;
    logic [CW-1:0]               sample;
    logic [CW-1:0]               phase;
    logic [31:0]                 cycadj;
    logic [15:0]                 window;
    logic [19:0]                 thresh;
    logic [NUM_SIDES-1:0][AW-1:0] acc;
    logic [NUM_SIDES-1:0][AW-1:0] acc_eff;
    logic [CW-1:0]               ctr;
    logic [CW-1:0]               st_tgt;
    logic [3:0]                  st_left;
    logic [7:0]                  idiv_cnt;
    logic [NUM_SIDES-1:0]        sense_ff1;
    logic [NUM_SIDES-1:0]        sense_ff2;
    logic [NUM_SIDES-1:0]        rect_prev;
    fe_win_e [NUM_SIDES-1:0]     win;
    logic [NUM_SIDES-1:0][7:0]   win_cnt;
    logic [NUM_SIDES-1:0][7:0]   meas;
    logic                        aw_held;
    logic [ADW-1:0]              aw_addr;
    logic                        w_held;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;
    fe_axi_resp_s                axi;
    logic                        side_a;
    logic                        side_b;
    logic [FW-1:0]               fine_a;
    logic [FW-1:0]               fine_b;
    logic [NUM_SIDES-1:0]        rect;
    logic                        sync_o;
    logic                        ec_trig;
    logic                        gc_trig;
    logic                        irq;
  } fe_state_s;
endpackage

// file: logic/fe_channel.sv
// Fine-edge pulse-width channel with oversampled triggers and rectifier dead-time loop
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
module fe_channel #(
  parameter int NUM_SYNC = 4
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_n_in,
  input  wire fe_pkg::fe_axi_req_s   axi_req_in,
  output fe_pkg::fe_axi_resp_s       axi_resp_out,
  input  wire logic [NUM_SYNC-1:0]   sync_in,
  input  wire logic                  conduction_sense_in_0,
  input  wire logic                  conduction_sense_in_1,
  output logic                       sync_out,
  output logic                       side_a_out,
  output logic                       side_b_out,
  output logic [fe_pkg::FW-1:0]      fine_a_out,
  output logic [fe_pkg::FW-1:0]      fine_b_out,
  output logic                       rectifier_gate_wave_0_out,
  output logic                       rectifier_gate_wave_1_out,
  output logic                       error_converter_trigger_out,
  output logic                       general_converter_trigger_out,
  output logic                       cpu_interrupt_out
);
  localparam int CW = fe_pkg::CW;
  localparam int EW = fe_pkg::EW;
  localparam int FW = fe_pkg::FW;
  localparam int AW = fe_pkg::AW;

  if (NUM_SYNC < 1 || NUM_SYNC > 4) begin : g_bad_sync
    $error("NUM_SYNC must lie between 1 and 4");
  end

  fe_pkg::fe_state_s          s;
  fe_pkg::fe_state_s          n;
  logic                       en;
  logic                       start;
  logic                       pend;
  logic                       sync_hit;
  logic                       auto_mode;
  logic                       mon_we;
  logic [3:0]                 idx;
  logic [1:0]                 os;
  logic [FW-1:0]              fmask;
  logic [2:0]                 scale;
  logic [1:0][EW-1:0]         fall_e;
  logic [1:0][EW-1:0]         rect_e;
  logic [1:0][EW-1:0]         lo_e;
  logic [1:0][15:0]           adj;
  logic [1:0]                 sense_raw;
  logic [31:0]                rd;
  logic [1:0]                 rd_resp;
  logic signed [AW:0]         sum;
  logic signed [AW:0]         delta;
  logic [EW-1:0]              hi_e;

  function automatic logic [EW-1:0] clamp_edge(input logic signed [EW+1:0] e,
                                               input logic [EW-1:0] lo,
                                               input logic [EW-1:0] hi);
    if (e < $signed({2'b00, lo})) return lo;
    if (e > $signed({2'b00, hi})) return hi;
    return e[EW-1:0];
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  be);
    logic [31:0] m;
    m = old;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) m[8*k +: 8] = d[8*k +: 8];
    end
    return m;
  endfunction

  assign sense_raw = {conduction_sense_in_1, conduction_sense_in_0};

  always_comb begin
    n         = s;
    en        = s.ctrl[fe_pkg::CTRL_EN];
    auto_mode = s.ctrl[fe_pkg::CTRL_AUTO];
    idx       = s.ctrl[fe_pkg::CTRL_IDIV +: 4];
    os        = s.ctrl[fe_pkg::CTRL_OS +: 2];
    scale     = s.ctrl[fe_pkg::CTRL_SCALE +: 3];
    sync_hit  = s.ctrl[fe_pkg::CTRL_FOLLOW] && sync_in[s.ctrl[fe_pkg::CTRL_SRC +: 2]];
    pend      = s.ctr >= s.period;
    start     = en && (pend || sync_hit);
    mon_we    = 1'b0;
    rd        = 32'h0000_0000;
    rd_resp   = fe_pkg::RESP_OKAY;
    sum       = '0;
    delta     = '0;
    hi_e      = {s.period, {FW{1'b0}}};
    adj[0]    = s.cycadj[15:0];
    adj[1]    = s.cycadj[31:16];
    lo_e[0]   = {s.event1, {FW{1'b0}}};
    lo_e[1]   = s.event3;

    // Two-flop synchroniser on the driver's conduction reports
    n.sense_ff1 = sense_raw;
    n.sense_ff2 = s.sense_ff1;

    // Ramp counter; a follower restarts it on its master's sync
    if (!en) begin
      n.ctr = '0;
    end else if (start) begin
      n.ctr = '0;
    end else begin
      n.ctr = CW'(s.ctr + 1'b1);
    end
    n.sync_o = en && (s.ctr == s.phase);

    // Falling edges with cycle adjust, then the rectifier edge moved by the accumulator
    for (int i = 0; i < 2; i++) begin
      fall_e[i] = clamp_edge($signed({2'b00, (i == 0) ? s.event2 : s.event4})
                             + $signed({{4{adj[i][15]}}, adj[i]}), lo_e[i], hi_e);
      rect_e[i] = clamp_edge($signed({2'b00, fall_e[i]})
                             + $signed({{(EW + 2 - AW - FW){s.acc_eff[i][AW-1]}},
                                        s.acc_eff[i], {FW{1'b0}}}),
                             lo_e[i], hi_e);
      n.rect[i] = en && (s.ctr >= lo_e[i][EW-1:FW]) && (s.ctr < rect_e[i][EW-1:FW]);
    end
    n.side_a = en && (s.ctr >= s.event1) && (s.ctr < fall_e[0][EW-1:FW]);
    n.side_b = en && (s.ctr >= s.event3[EW-1:FW]) && (s.ctr < fall_e[1][EW-1:FW]);

    // Sub-cycle phase select for the pending edge, coarsened by the step scale
    if (!s.ctrl[fe_pkg::CTRL_FINE] || scale >= fe_pkg::SCALE_MAX) begin
      fmask = '0;
    end else begin
      fmask = FW'({FW{1'b1}} << scale);
    end
    n.fine_a = (n.side_a ? fall_e[0][FW-1:0] : {FW{1'b0}}) & fmask;
    n.fine_b = (n.side_b ? fall_e[1][FW-1:0] : s.event3[FW-1:0]) & fmask;

    // Error converter triggers: first at the sample count, then every period/2^os
    n.ec_trig = en && (s.st_left != 4'h0) && (s.ctr == s.st_tgt);
    if (n.ec_trig) begin
      n.st_tgt  = CW'(s.st_tgt + (s.period >> os));
      n.st_left = s.st_left - 4'h1;
    end
    if (start) begin
      n.st_tgt  = s.sample;
      n.st_left = 4'(4'h1 << os);
    end

    // Period interrupt divider, shared with the general converter
    n.irq     = 1'b0;
    n.gc_trig = 1'b0;
    if (start && idx != 4'h0) begin
      if (s.idiv_cnt >= fe_pkg::IDIV_COUNT[idx]) begin
        n.irq      = 1'b1;
        n.gc_trig  = 1'b1;
        n.idiv_cnt = 8'h00;
      end else begin
        n.idiv_cnt = s.idiv_cnt + 8'h01;
      end
    end
    if (start) begin
      n.acc_eff = s.acc;
    end

    // Conduction detection windows, one per rectifier side
    n.rect_prev = s.rect;
    for (int i = 0; i < 2; i++) begin
      case (s.win[i])
        fe_pkg::FE_WIN_IDLE: begin
          if (s.rect_prev[i] && !s.rect[i]) begin
            n.win[i]     = fe_pkg::FE_WIN_BLANK;
            n.win_cnt[i] = s.window[7:0];
            n.meas[i]    = 8'h00;
          end
        end
        fe_pkg::FE_WIN_BLANK: begin
          if (s.win_cnt[i] == 8'h00) begin
            n.win[i]     = fe_pkg::FE_WIN_OPEN;
            n.win_cnt[i] = s.window[fe_pkg::WIN_LEN +: 8];
          end else begin
            n.win_cnt[i] = s.win_cnt[i] - 8'h01;
          end
        end
        fe_pkg::FE_WIN_OPEN: begin
          if (s.sense_ff2[i] && s.meas[i] != 8'hff) begin
            n.meas[i] = s.meas[i] + 8'h01;
          end
          if (s.win_cnt[i] == 8'h00) begin
            n.win[i] = fe_pkg::FE_WIN_IDLE;
            if (auto_mode) begin
              // Cleared per side so a step decided for one side never reaches the other
              delta = '0;
              if (n.meas[i] > s.thresh[fe_pkg::THR_HI +: 8]) begin
                delta = $signed({{(AW - 3){1'b0}}, s.thresh[fe_pkg::THR_STEP +: 4]});
              end else if (n.meas[i] < s.thresh[7:0]) begin
                delta = -$signed({{(AW - 3){1'b0}}, s.thresh[fe_pkg::THR_STEP +: 4]});
              end
              sum = $signed({s.acc[i][AW-1], s.acc[i]}) + delta;
              if (sum[AW] != sum[AW-1]) begin
                n.acc[i] = {sum[AW], {(AW - 1){~sum[AW]}}};
              end else begin
                n.acc[i] = sum[AW-1:0];
              end
            end
          end else begin
            n.win_cnt[i] = s.win_cnt[i] - 8'h01;
          end
        end
        default: begin
          n.win[i] = fe_pkg::FE_WIN_IDLE;
        end
      endcase
    end

    // Register read decode
    case (axi_req_in.araddr)
      fe_pkg::REG_CTRL:    rd = s.ctrl;
      fe_pkg::REG_PERIOD:  rd = 32'(s.period);
      fe_pkg::REG_EVENT1:  rd = 32'(s.event1);
      fe_pkg::REG_EVENT2:  rd = 32'(s.event2);
      fe_pkg::REG_EVENT3:  rd = 32'(s.event3);
      fe_pkg::REG_EVENT4:  rd = 32'(s.event4);
      fe_pkg::REG_SAMPLE:  rd = 32'(s.sample);
      fe_pkg::REG_PHASE:   rd = 32'(s.phase);
      fe_pkg::REG_CYCADJ:  rd = s.cycadj;
      fe_pkg::REG_WINDOW:  rd = 32'(s.window);
      fe_pkg::REG_THRESH:  rd = 32'(s.thresh);
      fe_pkg::REG_MONITOR: rd = {{(16 - AW){s.acc[1][AW-1]}}, s.acc[1],
                                 {(16 - AW){s.acc[0][AW-1]}}, s.acc[0]};
      fe_pkg::REG_STATUS:  rd = {2'b00, s.ctr, s.meas[1], s.meas[0]};
      default:             rd_resp = fe_pkg::RESP_SLVERR;
    endcase

    // Write channels are taken independently and committed once both are held
    if (s.axi.bvalid && axi_req_in.bready) n.axi.bvalid = 1'b0;
    if (s.axi.awready && axi_req_in.awvalid) begin
      n.aw_held = 1'b1;
      n.aw_addr = axi_req_in.awaddr;
    end
    if (s.axi.wready && axi_req_in.wvalid) begin
      n.w_held = 1'b1;
      n.wdata  = axi_req_in.wdata;
      n.wstrb  = axi_req_in.wstrb;
    end
    if (n.aw_held && n.w_held && !n.axi.bvalid) begin
      n.aw_held    = 1'b0;
      n.w_held     = 1'b0;
      n.axi.bvalid = 1'b1;
      n.axi.bresp  = fe_pkg::RESP_OKAY;
      case (n.aw_addr)
        fe_pkg::REG_CTRL:   n.ctrl = wmerge(s.ctrl, n.wdata, n.wstrb) & fe_pkg::CTRL_MASK;
        fe_pkg::REG_PERIOD: n.period = CW'(wmerge(32'(s.period), n.wdata, n.wstrb));
        fe_pkg::REG_EVENT1: n.event1 = CW'(wmerge(32'(s.event1), n.wdata, n.wstrb));
        fe_pkg::REG_EVENT2: n.event2 = EW'(wmerge(32'(s.event2), n.wdata, n.wstrb));
        fe_pkg::REG_EVENT3: n.event3 = EW'(wmerge(32'(s.event3), n.wdata, n.wstrb));
        fe_pkg::REG_EVENT4: n.event4 = EW'(wmerge(32'(s.event4), n.wdata, n.wstrb));
        fe_pkg::REG_SAMPLE: n.sample = CW'(wmerge(32'(s.sample), n.wdata, n.wstrb));
        fe_pkg::REG_PHASE:  n.phase = CW'(wmerge(32'(s.phase), n.wdata, n.wstrb));
        fe_pkg::REG_CYCADJ: n.cycadj = wmerge(s.cycadj, n.wdata, n.wstrb);
        fe_pkg::REG_WINDOW: n.window = 16'(wmerge(32'(s.window), n.wdata, n.wstrb));
        fe_pkg::REG_THRESH: n.thresh = 20'(wmerge(32'(s.thresh), n.wdata, n.wstrb));
        fe_pkg::REG_MONITOR: begin
          // Firmware owns the accumulators only outside automatic mode
          mon_we = !auto_mode;
          if (mon_we) begin
            n.acc[0] = n.wdata[AW-1:0];
            n.acc[1] = n.wdata[fe_pkg::HI_LSB +: AW];
          end
        end
        fe_pkg::REG_STATUS: n.axi.bresp = fe_pkg::RESP_OKAY;
        default:            n.axi.bresp = fe_pkg::RESP_SLVERR;
      endcase
    end
    n.axi.awready = !n.aw_held && !n.axi.bvalid;
    n.axi.wready  = !n.w_held && !n.axi.bvalid;

    if (s.axi.rvalid && axi_req_in.rready) n.axi.rvalid = 1'b0;
    if (s.axi.arready && axi_req_in.arvalid) begin
      n.axi.rvalid = 1'b1;
      n.axi.rdata  = rd;
      n.axi.rresp  = rd_resp;
    end
    n.axi.arready = !n.axi.rvalid;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s         <= '0;
      s.ctrl    <= fe_pkg::CTRL_RST;
      s.period  <= fe_pkg::PERIOD_RST;
      s.event2  <= fe_pkg::EVENT_RST;
      s.cycadj  <= fe_pkg::WORD_RST;
      s.win     <= '{fe_pkg::FE_WIN_IDLE, fe_pkg::FE_WIN_IDLE};
    end else begin
      s <= n;
    end
  end

  assign axi_resp_out                  = s.axi;
  assign sync_out                      = s.sync_o;
  assign side_a_out                    = s.side_a;
  assign side_b_out                    = s.side_b;
  assign fine_a_out                    = s.fine_a;
  assign fine_b_out                    = s.fine_b;
  assign rectifier_gate_wave_0_out     = s.rect[0];
  assign rectifier_gate_wave_1_out     = s.rect[1];
  assign error_converter_trigger_out   = s.ec_trig;
  assign general_converter_trigger_out = s.gc_trig;
  assign cpu_interrupt_out             = s.irq;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_irq_gc_pair: assert property (s.irq |-> s.gc_trig)
    else $error("interrupt without converter start");
  a_irq_cause: assert property (s.irq |-> $past(start)
      && ($past(s.idiv_cnt) >= fe_pkg::IDIV_COUNT[$past(idx)]))
    else $error("interrupt without divider terminal count");
  a_irq_off_zero: assert property (idx == 4'h0 |=> !s.irq)
    else $error("interrupt with divider disabled");
  a_trig_match: assert property (s.ec_trig |->
      $past(en && s.ctr == s.st_tgt && s.st_left != 4'h0))
    else $error("converter trigger off its count");
  a_os_budget: assert property (start |=> s.st_left == 4'(4'h1 << $past(os)))
    else $error("wrong number of triggers per period");
  a_sync_restart: assert property (en && sync_hit |=> s.ctr == '0)
    else $error("follower did not restart on sync");
  a_sync_emit: assert property (s.sync_o |-> $past(en && s.ctr == s.phase))
    else $error("sync out off the phase count");
  a_acc_manual: assert property (!auto_mode && !mon_we |=> $stable(s.acc))
    else $error("accumulator moved in manual mode");
  a_fine_off: assert property (!s.ctrl[fe_pkg::CTRL_FINE] |=>
      s.fine_a == '0 && s.fine_b == '0)
    else $error("fine phase while fine section off");
  a_fine_coarse: assert property (scale >= fe_pkg::SCALE_MAX |=>
      s.fine_a == '0 && s.fine_b == '0)
    else $error("fine phase at coarse step scale");
  a_rect_clamp: assert property ((lo_e[0] <= hi_e) |-> rect_e[0] <= hi_e
      && rect_e[0] >= lo_e[0])
    else $error("rectifier edge outside period");
  a_ctr_wrap: assert property (en && pend |=> s.ctr == '0)
    else $error("ramp did not restart at period end");
  a_eff_latch: assert property (start |=> s.acc_eff == $past(s.acc))
    else $error("edge adjustment not taken at period start");
  a_side_off: assert property (!en |=> !s.side_a && !s.side_b && s.rect == '0)
    else $error("output active while channel disabled");
  a_win_blank: assert property (s.win[0] == fe_pkg::FE_WIN_IDLE && s.rect_prev[0]
      && !s.rect[0] |=> s.win[0] == fe_pkg::FE_WIN_BLANK)
    else $error("detection window not opened after gate fall");
  a_meas_hold: assert property (s.win[0] == fe_pkg::FE_WIN_BLANK |=>
      $stable(s.meas[0]))
    else $error("conduction counted during blanking");
  a_bvalid_hold: assert property (s.axi.bvalid && !axi_req_in.bready |=> s.axi.bvalid)
    else $error("write response dropped");
endmodule

// file: testbench/fe_rect_drv.sv
// Rectifier gate driver model: reports diode conduction after each gate turn-off
module fe_rect_drv (
  input  wire logic       clk_in,
  input  wire logic [7:0] cond_in,
  input  wire logic [1:0] gate_in,
  output logic      [1:0] sense_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] prev = 2'h0;
  logic [7:0] left [2] = '{8'h00, 8'h00};
  always @(posedge clk_in) begin
    prev <= gate_in;
    for (int i = 0; i < 2; i++) begin
      if (prev[i] && !gate_in[i]) left[i] <= cond_in;
      else if (left[i] != 8'h00) left[i] <= left[i] - 8'h01;
    end
  end
  // Driven low between conduction intervals, never left floating
  assign sense_out = {left[1] != 8'h00, left[0] != 8'h00};
endmodule

// file: testbench/test_fe_channel.sv
// Self-checking bench of the fine-edge channel
module test_fe_channel;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 63;
  logic                 sys_clk_in = 1'b0;
  logic                 rst_n_in = 1'b0;
  fe_pkg::fe_axi_req_s  req = '0;
  fe_pkg::fe_axi_resp_s rsp;
  logic [3:0]           sync_in = 4'h0;
  logic [7:0]           cond = 8'h0c;
  logic [1:0]           gate, sense, rr;
  logic                 ec, gc, irq, so;
  logic                 sa, sb;
  logic [3:0]           fa, fb;
  logic [31:0]          rd;
  int                   n_mismatch = 0;
  int                   num_checks = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  fe_channel uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .axi_req_in(req),
    .axi_resp_out(rsp), .sync_in(sync_in), .conduction_sense_in_0(sense[0]),
    .conduction_sense_in_1(sense[1]), .sync_out(so), .side_a_out(sa), .side_b_out(sb),
    .fine_a_out(fa), .fine_b_out(fb), .rectifier_gate_wave_0_out(gate[0]),
    .rectifier_gate_wave_1_out(gate[1]), .error_converter_trigger_out(ec),
    .general_converter_trigger_out(gc), .cpu_interrupt_out(irq));
  fe_rect_drv drv (.clk_in(sys_clk_in), .cond_in(cond), .gate_in(gate), .sense_out(sense));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    num_checks++;
    if (v !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, e, v);
    end
  endtask
  // Handshakes are judged at the falling edge, so the release lands right after the taking edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    fe_pkg::fe_axi_req_s nx;
    logic fin;
    @(posedge sys_clk_in);
    req <= '{w, a, w, d, 4'hf, w, !w, a, !w};
    forever begin
      @(negedge sys_clk_in);
      nx = req;
      fin = (req.bready && rsp.bvalid) || (req.rready && rsp.rvalid);
      nx.awvalid = req.awvalid && !rsp.awready;
      nx.wvalid = req.wvalid && !rsp.wready;
      nx.arvalid = req.arvalid && !rsp.arready;
      nx.bready = req.bready && !fin;
      nx.rready = req.rready && !fin;
      rd = rsp.rdata;
      rr = w ? rsp.bresp : rsp.rresp;
      @(posedge sys_clk_in);
      req <= nx;
      if (fin) break;
    end
  endtask
  task automatic t_reset;
    bus(1'b0, fe_pkg::REG_PERIOD, 32'h0);
    chk("period_reset", 32'h0000_00f9, rd);
    bus(1'b0, fe_pkg::REG_MONITOR, 32'h0);
    chk("acc_reset", 32'h0, rd);
    bus(1'b0, 8'hfc, 32'h0);
    chk("unmapped_resp", 32'h2, {30'h0, rr});
    $display("test reset done");
  endtask
  task automatic t_ovs;
    int q[$];
    bus(1'b1, fe_pkg::REG_PERIOD, P);
    bus(1'b1, fe_pkg::REG_SAMPLE, 32'h1);
    for (int os = 0; os < 4; os++) begin
      bus(1'b1, fe_pkg::REG_CTRL, 32'h1 | (os << 5));
      q = {};
      // Skip one period so the new setting has been latched at a period start
      repeat (2) do @(negedge sys_clk_in); while (so !== 1'b1);
      for (int i = 1; i <= P + 1; i++) begin
        @(negedge sys_clk_in);
        if (ec === 1'b1) q.push_back(i);
      end
      chk("sync_gap", 32'h1, {31'h0, so});
      chk("trig_count", 1 << os, q.size());
      chk("trig_first", 32'h1, q[0]);
      if (os > 0) chk("trig_step", P >> os, q[1] - q[0]);
    end
    $display("test oversampling done");
  endtask
  task automatic t_irq;
    int st [6] = '{1, 2, 3, 4, 7, 15};
    int cnt [6] = '{0, 1, 3, 7, 47, 255};
    int n;
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, fe_pkg::REG_CTRL, 32'h1 | (st[k] << 10));
      do @(negedge sys_clk_in); while (irq !== 1'b1);
      n = 0;
      do begin
        @(negedge sys_clk_in);
        n++;
      end while (irq !== 1'b1);
      chk("irq_gap", (cnt[k] + 1) * (P + 1), n);
      chk("adc_start", 32'h1, {31'h0, gc});
    end
    $display("test interrupt done");
  endtask
  task automatic t_dtc;
    bus(1'b1, fe_pkg::REG_EVENT2, 32'h140);
    bus(1'b1, fe_pkg::REG_EVENT3, 32'h200);
    bus(1'b1, fe_pkg::REG_EVENT4, 32'h280);
    bus(1'b1, fe_pkg::REG_WINDOW, 32'h800);
    bus(1'b1, fe_pkg::REG_THRESH, 32'h1_0603);
    bus(1'b1, fe_pkg::REG_CTRL, 32'h4001);
    repeat (10 * (P + 1)) @(posedge sys_clk_in);
    bus(1'b0, fe_pkg::REG_STATUS, 32'h0);
    chk("meas_long", 32'h1, {31'h0, rd[7:0] > 8'h06});
    bus(1'b0, fe_pkg::REG_MONITOR, 32'h0);
    chk("acc_up", 32'h1, {31'h0, !rd[15] && !rd[31] && rd[11:0] != 0});
    cond <= 8'h00;
    repeat (20 * (P + 1)) @(posedge sys_clk_in);
    bus(1'b0, fe_pkg::REG_MONITOR, 32'h0);
    chk("acc_down", 32'h1, {31'h0, rd[15] && rd[31]});
    bus(1'b1, fe_pkg::REG_CTRL, 32'h1);
    bus(1'b1, fe_pkg::REG_MONITOR, 32'h0005_0ffd);
    repeat (3 * (P + 1)) @(posedge sys_clk_in);
    bus(1'b0, fe_pkg::REG_MONITOR, 32'h0);
    chk("acc_manual", 32'h0005_fffd, rd);
    $display("test dead time done");
  endtask
  task automatic t_edges;
    logic [3:0] ea [3] = '{4'hb, 4'h8, 4'h0};
    logic [3:0] eb [3] = '{4'h7, 4'h4, 4'h0};
    int na;
    int nb;
    bus(1'b1, fe_pkg::REG_EVENT2, 32'h14b);
    bus(1'b1, fe_pkg::REG_EVENT4, 32'h287);
    bus(1'b1, fe_pkg::REG_CYCADJ, 32'hfff0_0020);
    bus(1'b1, fe_pkg::REG_PHASE, 32'h5);
    // Step scale 250 ps, 1 ns, then coarse; follower enabled with its sync held low
    for (int sc = 0; sc < 3; sc++) begin
      bus(1'b1, fe_pkg::REG_CTRL, 32'h83 | (sc << 3));
      repeat (P + 1) @(negedge sys_clk_in);
      na = 0;
      nb = 0;
      for (int i = 0; i <= P; i++) begin
        @(negedge sys_clk_in);
        na += int'(sa === 1'b1);
        nb += int'(sb === 1'b1);
        if (sa === 1'b1) chk("fine_a", ea[sc], fa);
        if (sb === 1'b1) chk("fine_b", eb[sc], fb);
      end
      chk("side_a_len", 22, na);
      chk("side_b_len", 7, nb);
    end
    do @(negedge sys_clk_in); while (so !== 1'b1);
    repeat (20) @(posedge sys_clk_in);
    sync_in <= 4'h1;
    @(posedge sys_clk_in);
    sync_in <= 4'h0;
    repeat (6) @(negedge sys_clk_in);
    chk("sync_early", 0, so);
    @(negedge sys_clk_in);
    chk("sync_phase", 1, so);
    $display("test edges done");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_ovs();
    t_irq();
    t_dtc();
    t_edges();
    finish_test();
  end
  // The tests need about 45,000 cycles; the limit leaves a margin above that
  initial begin
    #240000;
    n_mismatch++;
    finish_test();
  end
endmodule
